// ==== inc/hp_slot_pkg.sv ====
package hp_slot_pkg;

  // =====================================================================
  // register map
  localparam int              ADDR_W       = 12;
  localparam logic [11:0]     SLOT_CAP_OFS = 12'h0d4;
  localparam logic [11:0]     SLOT_CTL_OFS = 12'h0d8;

  // =====================================================================
  // reset values and write masks
  localparam logic [31:0]     CAP_RST      = 32'h0000_0000;
  localparam logic [31:0]     CAP_SW_MASK  = 32'h0001_ff80;
  localparam logic [31:0]     CAP_OVR_MASK = 32'hfff9_fffb;
  localparam logic [15:0]     CTL_RST      = 16'h03c0;
  localparam logic [15:0]     CTL_SW_MASK  = 16'h17fb;
  // status flags {dll, cmd_done, pres_chg, pwr_fault, att_btn}
  localparam logic [4:0]      EVT_RST      = 5'h10;

  // =====================================================================
  // slot control field positions
  localparam int              CTL_ABP_EN   = 0;
  localparam int              CTL_PFD_EN   = 1;
  localparam int              CTL_PDC_EN   = 3;
  localparam int              CTL_CC_EN    = 4;
  localparam int              CTL_HPI_EN   = 5;
  localparam int              CTL_ATT_LO   = 6;
  localparam int              CTL_PWI_LO   = 8;
  localparam int              CTL_PWR_OFF  = 10;
  localparam int              CTL_DLL_EN   = 12;

  // status bit positions inside the upper half of the control word
  localparam int              ST_ABP       = 0;
  localparam int              ST_PFD       = 1;
  localparam int              ST_PDC       = 3;
  localparam int              ST_CC        = 4;
  localparam int              ST_DLL       = 8;

  // indicator encodings
  localparam logic [1:0]      IND_RSVD     = 2'h0;
  localparam logic [1:0]      IND_ON       = 2'h1;
  localparam logic [1:0]      IND_BLINK    = 2'h2;
  localparam logic [1:0]      IND_OFF      = 2'h3;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic [12:0] slot_num;
    logic [1:0]  rsvd_hi;
    logic [1:0]  pl_scale;
    logic [7:0]  pl_value;
    logic        hp_capable;
    logic        hp_surprise;
    logic        pwr_ind_present;
    logic        att_ind_present;
    logic        rsvd_lo;
    logic        pwr_ctrl_present;
    logic        att_btn_present;
  } slot_cap_t;

  localparam int              MSG_DW       = 10;
  localparam int              MSG_KINDS    = 3;

  typedef enum logic [1:0] {MSG_NONE, MSG_PWR_LIMIT, MSG_ATT_IND, MSG_PWR_IND} msg_kind_t;

  typedef struct packed {
    msg_kind_t           kind;
    logic [MSG_DW-1:0]   data;
  } slot_msg_t;

endpackage : hp_slot_pkg

// ==== hw/slot_msg_queue.sv ====
`timescale 1ns/1ns
module slot_msg_queue import hp_slot_pkg::*; #(
  parameter int KINDS = MSG_KINDS,
  parameter int DW    = MSG_DW
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // requests, index 0 has highest priority
  input  wire logic [KINDS-1:0]         req,
  input  wire logic [KINDS-1:0][DW-1:0] req_data,
  // message out
  output logic                          out_valid,
  output slot_msg_t                     out_msg,
  input  wire logic                     out_ready
);

  // =====================================================================
  // one pending slot per message kind; a newer write replaces the payload
  logic [KINDS-1:0]         pend_ff;
  logic [KINDS-1:0][DW-1:0] data_ff;
  logic [KINDS-1:0]         gnt;
  logic [KINDS-1:0]         take;
  logic                     load;
  logic                     nxt_valid;
  slot_msg_t                nxt_msg;
  logic [1:0]               gnt_idx;

  assign load = (~out_valid | out_ready) & (|pend_ff);
  assign take = gnt & {KINDS{load}};

  genvar g;
  generate
    for (g = 0; g < KINDS; g++) begin : g_kind
      if (g == 0) begin : g_top
        assign gnt[g] = pend_ff[g];
      end else begin : g_low
        assign gnt[g] = pend_ff[g] & ~(|pend_ff[g-1:0]);
      end
      // a request in the cycle of its own take stays pending
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_ff[g] <= 1'b0;
          data_ff[g] <= '0;
        end else begin
          pend_ff[g] <= (pend_ff[g] & ~take[g]) | req[g];
          if (req[g]) data_ff[g] <= req_data[g];
        end
      end
    end
  endgenerate

  assign gnt_idx      = gnt[0] ? 2'h0 : (gnt[1] ? 2'h1 : 2'h2);
  assign nxt_valid    = load | (out_valid & ~out_ready);
  assign nxt_msg.kind = msg_kind_t'(gnt_idx + 2'h1);
  assign nxt_msg.data = data_ff[gnt_idx];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_msg   <= '{kind: MSG_NONE, data: '0};
    end else begin
      out_valid <= nxt_valid;
      if (load) out_msg <= nxt_msg;
    end
  end

  a_msg_hold: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_msg))
    else $error("message changed while stalled");

endmodule : slot_msg_queue

// ==== hw/hot_plug_slot_cap_control.sv ====
`timescale 1ns/1ns
module hot_plug_slot_cap_control import hp_slot_pkg::*; (
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RESETN,
  // configuration access
  input  wire logic [ADDR_W-1:0] CFG_ADDR,
  input  wire logic              CFG_WR,
  input  wire logic              CFG_RD,
  input  wire logic [3:0]        CFG_BE,
  input  wire logic [31:0]       CFG_WDATA,
  output logic [31:0]            CFG_RDATA,
  output logic                   CFG_RVALID,
  // capability override
  input  wire logic              SMB_CAP_WE,
  input  wire logic [31:0]       SMB_CAP_DATA,
  input  wire logic              EE_CAP_WE,
  input  wire logic [31:0]       EE_CAP_DATA,
  // slot events
  input  wire logic              ATT_BTN_PRESS,
  input  wire logic              PWR_FAULT,
  input  wire logic              PRES_CHANGE,
  input  wire logic              CMD_DONE,
  input  wire logic              DL_STATE_ACTIVE,
  // slot controls
  output logic [1:0]             ATT_IND,
  output logic [1:0]             PWR_IND,
  output logic                   SLOT_PWR_OFF,
  output logic                   LINK_ACTIVE,
  output logic                   HP_INT,
  output logic                   WAKE_REQ,
  // link messages
  output logic                   MSG_VALID,
  output slot_msg_t              MSG_OUT,
  input  wire logic              MSG_READY
);

  // =====================================================================
  // decode
  logic        cap_sel;
  logic        ctl_sel;
  logic        cap_wr;
  logic        ctl_wr;
  logic [31:0] be_mask;

  assign cap_sel = CFG_ADDR[ADDR_W-1:2] == SLOT_CAP_OFS[ADDR_W-1:2];
  assign ctl_sel = CFG_ADDR[ADDR_W-1:2] == SLOT_CTL_OFS[ADDR_W-1:2];
  assign cap_wr  = CFG_WR & cap_sel;
  assign ctl_wr  = CFG_WR & ctl_sel;
  assign be_mask = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};

  // =====================================================================
  // slot capability
  slot_cap_t   cap_ff;
  slot_cap_t   nxt_cap;
  slot_cap_t   sw_cap;
  slot_cap_t   ovr_cap;
  logic        ovr_we;
  logic [31:0] cap_wm;

  // sideband wins over eeprom, and both win over a software write
  assign ovr_we  = SMB_CAP_WE | EE_CAP_WE;
  assign ovr_cap = slot_cap_t'((SMB_CAP_WE ? SMB_CAP_DATA : EE_CAP_DATA) & CAP_OVR_MASK);
  assign cap_wm  = be_mask & CAP_SW_MASK & {32{cap_wr}};
  assign sw_cap  = slot_cap_t'((cap_ff & ~cap_wm) | (CFG_WDATA & cap_wm));

  assign nxt_cap.att_btn_present  = ovr_we ? ovr_cap.att_btn_present : cap_ff.att_btn_present;
  assign nxt_cap.pwr_ctrl_present = ovr_we ? ovr_cap.pwr_ctrl_present : cap_ff.pwr_ctrl_present;
  assign nxt_cap.rsvd_lo          = 1'b0;
  assign nxt_cap.att_ind_present  = ovr_we ? ovr_cap.att_ind_present : cap_ff.att_ind_present;
  assign nxt_cap.pwr_ind_present  = ovr_we ? ovr_cap.pwr_ind_present : cap_ff.pwr_ind_present;
  assign nxt_cap.hp_surprise      = ovr_we ? ovr_cap.hp_surprise : cap_ff.hp_surprise;
  assign nxt_cap.hp_capable       = ovr_we ? ovr_cap.hp_capable : cap_ff.hp_capable;
  assign nxt_cap.pl_value         = ovr_we ? ovr_cap.pl_value : sw_cap.pl_value;
  assign nxt_cap.pl_scale         = ovr_we ? ovr_cap.pl_scale : sw_cap.pl_scale;
  assign nxt_cap.rsvd_hi          = 2'h0;
  assign nxt_cap.slot_num         = ovr_we ? ovr_cap.slot_num : cap_ff.slot_num;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) cap_ff <= slot_cap_t'(CAP_RST);
    else         cap_ff <= nxt_cap;
  end

  // =====================================================================
  // slot control
  logic [15:0] ctl_ff;
  logic [15:0] nxt_ctl;
  logic [15:0] ctl_wm;
  logic [15:0] ctl_merge;
  logic [1:0]  att_new;
  logic [1:0]  pwi_new;
  logic        att_wr;
  logic        pwi_wr;

  assign ctl_wm    = be_mask[15:0] & CTL_SW_MASK & {16{ctl_wr}};
  assign ctl_merge = (ctl_ff & ~ctl_wm) | (CFG_WDATA[15:0] & ctl_wm);
  assign att_new   = CFG_WDATA[CTL_ATT_LO+:2];
  assign pwi_new   = CFG_WDATA[CTL_PWI_LO+:2];
  // the reserved code is dropped so an indicator never lands in an undefined state
  assign att_wr    = ctl_wr & CFG_BE[0] & (att_new != IND_RSVD);
  assign pwi_wr    = ctl_wr & CFG_BE[1] & (pwi_new != IND_RSVD);

  always_comb begin
    nxt_ctl = ctl_merge;
    nxt_ctl[CTL_ATT_LO+:2] = att_wr ? att_new : ctl_ff[CTL_ATT_LO+:2];
    nxt_ctl[CTL_PWI_LO+:2] = pwi_wr ? pwi_new : ctl_ff[CTL_PWI_LO+:2];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) ctl_ff <= CTL_RST;
    else         ctl_ff <= nxt_ctl;
  end

  // =====================================================================
  // event flags, write one to clear in the upper half of the control word
  logic [4:0]  evt_ff;
  logic [4:0]  nxt_evt;
  logic [4:0]  evt_set;
  logic [4:0]  evt_clr;
  logic [4:0]  evt_en;
  logic [15:0] st_clr;
  logic        dl_chg;

  assign st_clr  = CFG_WDATA[31:16] & be_mask[31:16] & {16{ctl_wr}};
  assign dl_chg  = DL_STATE_ACTIVE != LINK_ACTIVE;
  assign evt_set = {dl_chg, CMD_DONE, PRES_CHANGE, PWR_FAULT, ATT_BTN_PRESS};
  assign evt_clr = {st_clr[ST_DLL], st_clr[ST_CC], st_clr[ST_PDC], st_clr[ST_PFD], st_clr[ST_ABP]};
  // a new event in the clearing cycle survives the clear
  assign nxt_evt = (evt_ff & ~evt_clr) | evt_set;
  assign evt_en  = {ctl_ff[CTL_DLL_EN], ctl_ff[CTL_CC_EN], ctl_ff[CTL_PDC_EN],
                    ctl_ff[CTL_PFD_EN], ctl_ff[CTL_ABP_EN]};

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      evt_ff      <= EVT_RST;
      LINK_ACTIVE <= 1'b0;
    end else begin
      evt_ff      <= nxt_evt;
      LINK_ACTIVE <= DL_STATE_ACTIVE;
    end
  end

  // =====================================================================
  // interrupt and wake
  logic        evt_pend;
  logic        wake_pend;
  logic        nxt_int;
  logic        nxt_wake;

  assign evt_pend  = |(evt_ff & evt_en);
  // command completion is interrupt only, it never wakes the system
  assign wake_pend = |(evt_ff[3:0] & evt_en[3:0] & 4'h7);
  assign nxt_int   = ctl_ff[CTL_HPI_EN] & evt_pend;
  assign nxt_wake  = ~ctl_ff[CTL_HPI_EN] & wake_pend;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HP_INT   <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      HP_INT   <= nxt_int;
      WAKE_REQ <= nxt_wake;
    end
  end

  // =====================================================================
  // slot outputs follow the control register
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ATT_IND      <= CTL_RST[CTL_ATT_LO+:2];
      PWR_IND      <= CTL_RST[CTL_PWI_LO+:2];
      SLOT_PWR_OFF <= CTL_RST[CTL_PWR_OFF];
    end else begin
      ATT_IND      <= nxt_ctl[CTL_ATT_LO+:2];
      PWR_IND      <= nxt_ctl[CTL_PWI_LO+:2];
      SLOT_PWR_OFF <= nxt_ctl[CTL_PWR_OFF];
    end
  end

  // =====================================================================
  // read port, one cycle latency, unmapped reads return zero
  logic [31:0] rd_mux;
  logic [15:0] st_word;

  assign st_word = {7'h00, evt_ff[4], 3'h0, evt_ff[3], evt_ff[2], 1'b0, evt_ff[1], evt_ff[0]};
  assign rd_mux  = cap_sel ? 32'(cap_ff) : (ctl_sel ? {st_word, ctl_ff} : 32'h0000_0000);

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CFG_RDATA  <= 32'h0000_0000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD) CFG_RDATA <= rd_mux;
    end
  end

  // =====================================================================
  // messages toward the card
  logic                            pl_wr;
  logic [MSG_KINDS-1:0]            msg_req;
  logic [MSG_KINDS-1:0][MSG_DW-1:0] msg_data;

  assign pl_wr    = cap_wr & (|CFG_BE[2:0]);
  assign msg_req  = {pwi_wr, att_wr, pl_wr};
  assign msg_data = {{8'h00, pwi_new}, {8'h00, att_new}, {sw_cap.pl_scale, sw_cap.pl_value}};

  slot_msg_queue #(
    .KINDS     (MSG_KINDS),
    .DW        (MSG_DW)
  ) u_msg_queue (
    .clk       (SYS_CLK),
    .rst_n     (RESETN),
    .req       (msg_req),
    .req_data  (msg_data),
    .out_valid (MSG_VALID),
    .out_msg   (MSG_OUT),
    .out_ready (MSG_READY)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  a_ro_cap_hold: assert property (cap_wr && !ovr_we |=> $stable(cap_ff.slot_num) &&
    $stable(cap_ff.att_btn_present) && $stable(cap_ff.hp_capable) && !cap_ff.rsvd_lo)
    else $error("read-only capability changed by software");
  a_ovr_load: assert property (SMB_CAP_WE |=> 32'(cap_ff) == ($past(SMB_CAP_DATA) & CAP_OVR_MASK))
    else $error("sideband load not taken");
  a_pl_write: assert property (cap_wr && CFG_BE[1] && CFG_BE[0] && !ovr_we |=>
    cap_ff.pl_value == $past(CFG_WDATA[14:7]))
    else $error("power limit value not written");
  a_pl_msg: assert property (pl_wr |-> ##[1:2] MSG_VALID)
    else $error("no power limit message after write");
  a_att_msg: assert property (att_wr && !MSG_VALID && $past(msg_req) == 3'h0 |->
    ##2 MSG_VALID && MSG_OUT.kind == MSG_ATT_IND && MSG_OUT.data[1:0] == $past(att_new, 2))
    else $error("attention message missing or wrong");
  a_pwi_msg: assert property (pwi_wr |-> ##[1:2] MSG_VALID)
    else $error("no power indicator message after write");
  a_ind_rsvd: assert property (ctl_wr && CFG_BE[0] && att_new == IND_RSVD |=> $stable(ATT_IND))
    else $error("reserved attention code accepted");
  a_pwr_ctrl: assert property (ctl_wr && CFG_BE[1] |=> SLOT_PWR_OFF == $past(CFG_WDATA[CTL_PWR_OFF]))
    else $error("slot power state not following write");
  a_int_master: assert property (!ctl_ff[CTL_HPI_EN] |=> !HP_INT)
    else $error("interrupt without master enable");
  a_int_source: assert property (ctl_ff[CTL_HPI_EN] && evt_pend |=> HP_INT)
    else $error("enabled event did not interrupt");
  a_dll_flag: assert property ($changed(LINK_ACTIVE) |-> evt_ff[4])
    else $error("link active change not flagged");
  a_set_wins: assert property (ATT_BTN_PRESS && st_clr[ST_ABP] |=> evt_ff[0])
    else $error("event lost against clear");

  // flags, link state, wake, reserved bits and power limit scale
  a_link_follow: assert property (LINK_ACTIVE == $past(DL_STATE_ACTIVE))
    else $error("link active not following link state");
  a_dll_clr: assert property (st_clr[ST_DLL] && !dl_chg |=> !evt_ff[4])
    else $error("link change flag not cleared by write of one");
  a_abp_set: assert property (ATT_BTN_PRESS |=> evt_ff[0])
    else $error("button press not flagged");
  a_pfd_set: assert property (PWR_FAULT |=> evt_ff[1])
    else $error("power fault not flagged");
  a_pdc_set: assert property (PRES_CHANGE |=> evt_ff[2])
    else $error("presence change not flagged");
  a_cc_set: assert property (CMD_DONE |=> evt_ff[3])
    else $error("command completion not flagged");
  a_wake_gate: assert property (!ctl_ff[CTL_HPI_EN] && wake_pend |=> WAKE_REQ)
    else $error("enabled event did not wake");
  a_cc_no_wake: assert property (!(|(evt_ff[2:0] & evt_en[2:0])) |=> !WAKE_REQ)
    else $error("wake without an enabled wake source");
  a_ctl_rsvd: assert property (!ctl_ff[2] && !ctl_ff[11] && ctl_ff[15:13] == 3'h0)
    else $error("reserved control bit set");
  a_cap_rsvd: assert property (!cap_ff.rsvd_lo && cap_ff.rsvd_hi == 2'h0)
    else $error("reserved capability bit set");
  a_pwi_rsvd: assert property (ctl_wr && CFG_BE[1] && pwi_new == IND_RSVD |=> $stable(PWR_IND))
    else $error("reserved power indicator code accepted");
  a_pl_scale: assert property (cap_wr && CFG_BE[2] && CFG_BE[1] && !ovr_we |=>
    cap_ff.pl_scale == $past(CFG_WDATA[16:15]))
    else $error("power limit scale not written");

endmodule : hot_plug_slot_cap_control

// ==== dv/slot_card_model.sv ====
`timescale 1ns/1ns
// =====================================================================
// card in the slot: takes link messages, stalling at random when slow
module slot_card_model import hp_slot_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // message link
  input  wire logic       msg_valid,
  input  wire slot_msg_t  msg,
  output logic            msg_ready,
  // mode and delivery to the bench
  input  wire logic       slow,
  output logic            got,
  output slot_msg_t       got_msg
);
  integer seed = 32'h0605;

  // ready changes only just after an edge, so an offered message is held
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_ready <= 1'h0;
      got       <= 1'h0;
      got_msg   <= '0;
    end else begin
      got       <= msg_valid & msg_ready;
      got_msg   <= msg;
      msg_ready <= slow ? 1'($random(seed)) : 1'h1;
    end
  end
endmodule : slot_card_model

// ==== dv/tb_hot_plug_slot_cap_control.sv ====
`timescale 1ns/1ns
module tb_hot_plug_slot_cap_control import hp_slot_pkg::*;;
  logic              SYS_CLK, RESETN, CFG_WR, CFG_RD, CFG_RVALID;
  logic [ADDR_W-1:0] CFG_ADDR;
  logic [3:0]        CFG_BE, ev;
  logic [31:0]       CFG_WDATA, CFG_RDATA, SMB_CAP_DATA, EE_CAP_DATA, r;
  logic              SMB_CAP_WE, EE_CAP_WE, DL_STATE_ACTIVE, SLOT_PWR_OFF, LINK_ACTIVE;
  logic              HP_INT, WAKE_REQ, MSG_VALID, MSG_READY, got, slow;
  logic [1:0]        ATT_IND, PWR_IND;
  slot_msg_t         MSG_OUT, got_msg;
  logic [31:0]       exp_rd[$];
  slot_msg_t         exp_msg[$];
  logic [31:0]       cap_exp;
  logic [15:0]       ctl_exp;
  integer            seed = 32'h0605;
  int                err_count = 0;
  int                tests_run = 0;
  int                evb[4] = '{0, 1, 3, 4};

  hot_plug_slot_cap_control hot_plug_slot_cap_control_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID), .SMB_CAP_WE(SMB_CAP_WE), .SMB_CAP_DATA(SMB_CAP_DATA),
    .EE_CAP_WE(EE_CAP_WE), .EE_CAP_DATA(EE_CAP_DATA), .ATT_BTN_PRESS(ev[0]), .PWR_FAULT(ev[1]),
    .PRES_CHANGE(ev[2]), .CMD_DONE(ev[3]), .DL_STATE_ACTIVE(DL_STATE_ACTIVE), .ATT_IND(ATT_IND),
    .PWR_IND(PWR_IND), .SLOT_PWR_OFF(SLOT_PWR_OFF), .LINK_ACTIVE(LINK_ACTIVE), .HP_INT(HP_INT),
    .WAKE_REQ(WAKE_REQ), .MSG_VALID(MSG_VALID), .MSG_OUT(MSG_OUT), .MSG_READY(MSG_READY));

  slot_card_model slot_card_model_inst (.clk(SYS_CLK), .rst_n(RESETN), .msg_valid(MSG_VALID),
    .msg(MSG_OUT), .msg_ready(MSG_READY), .slow(slow), .got(got), .got_msg(got_msg));

  // =====================================================================
  // compare and closing
  task automatic chk_val(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_msg(slot_msg_t g, slot_msg_t e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_msg

  task automatic results();
    if (exp_rd.size() != 0 || exp_msg.size() != 0) err_count++;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // =====================================================================
  // drivers: rd, wcap, wctl and ovr note what they expect before making the request; wr notes nothing
  task automatic wr(logic [11:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge SYS_CLK);
    CFG_ADDR  <= a;
    CFG_BE    <= be;
    CFG_WDATA <= d;
    CFG_WR    <= 1'h1;
    @(posedge SYS_CLK);
    CFG_WR    <= 1'h0;
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge SYS_CLK);
    CFG_ADDR <= a;
    CFG_RD   <= 1'h1;
    @(posedge SYS_CLK);
    CFG_RD   <= 1'h0;
  endtask : rd

  task automatic wcap(logic [31:0] d);
    cap_exp = (cap_exp & ~CAP_SW_MASK) | (d & CAP_SW_MASK);
    exp_msg.push_back({MSG_PWR_LIMIT, cap_exp[16:7]});
    wr(SLOT_CAP_OFS, 4'hf, d);
  endtask : wcap

  // reserved indicator code keeps the old state and sends nothing
  task automatic wctl(logic [15:0] d);
    logic [15:0] n;
    n = (ctl_exp & ~CTL_SW_MASK) | (d & CTL_SW_MASK);
    if (d[7:6] == IND_RSVD) n[7:6] = ctl_exp[7:6];
    else exp_msg.push_back({MSG_ATT_IND, 8'h00, d[7:6]});
    if (d[9:8] == IND_RSVD) n[9:8] = ctl_exp[9:8];
    else exp_msg.push_back({MSG_PWR_IND, 8'h00, d[9:8]});
    ctl_exp = n;
    wr(SLOT_CTL_OFS, 4'h3, {16'h0000, d});
  endtask : wctl

  task automatic ovr(logic smb, logic [31:0] d);
    cap_exp = (smb ? d : ~d) & CAP_OVR_MASK;
    @(posedge SYS_CLK);
    SMB_CAP_DATA <= d;
    EE_CAP_DATA  <= ~d;
    SMB_CAP_WE   <= smb;
    EE_CAP_WE    <= 1'h1;
    @(posedge SYS_CLK);
    SMB_CAP_WE   <= 1'h0;
    EE_CAP_WE    <= 1'h0;
  endtask : ovr

  task automatic drain();
    int n;
    for (n = 0; n < 60 && (exp_rd.size() != 0 || exp_msg.size() != 0); n++) @(negedge SYS_CLK);
    if (exp_rd.size() != 0 || exp_msg.size() != 0) chk_val(32'h0000_0001, 32'h0000_0000);
  endtask : drain

  // =====================================================================
  // monitors: an unexpected result meets an unknown note and fails
  always @(negedge SYS_CLK) begin
    if (CFG_RVALID === 1'h1) chk_val(CFG_RDATA, exp_rd.size() ? exp_rd.pop_front() : 32'hxxxx_xxxx);
    if (got === 1'h1) chk_msg(got_msg, exp_msg.size() ? exp_msg.pop_front() : 12'hxxx);
  end

  initial begin
    SYS_CLK = 1'h0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  // run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    err_count++;
    results();
  end

  // =====================================================================
  // main sequence
  initial begin
    {RESETN, CFG_WR, CFG_RD, SMB_CAP_WE, EE_CAP_WE, DL_STATE_ACTIVE, slow} = '0;
    {CFG_ADDR, CFG_BE, ev, CFG_WDATA, SMB_CAP_DATA, EE_CAP_DATA} = '0;
    cap_exp = CAP_RST;
    ctl_exp = CTL_RST;
    repeat (5) @(posedge SYS_CLK);
    RESETN <= 1'h1;
    @(negedge SYS_CLK);
    chk_val(32'(ATT_IND), 32'(IND_OFF));
    chk_val(32'(PWR_IND), 32'(IND_OFF));
    chk_val(32'(SLOT_PWR_OFF), 32'h0000_0000);
    rd(SLOT_CAP_OFS, CAP_RST);
    rd(SLOT_CTL_OFS, {16'h0100, CTL_RST});
    wcap(32'hffff_ffff);
    rd(SLOT_CAP_OFS, cap_exp);
    drain();
    slow <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      wcap($random(seed));
      rd(SLOT_CAP_OFS, cap_exp);
      drain();
    end
    for (int i = 1; i < 5; i++) begin
      wctl(16'((i % 4 == 2) << CTL_PWR_OFF | (4 - i) % 4 << CTL_PWI_LO | i % 4 << CTL_ATT_LO));
      drain();
      chk_val(32'(ATT_IND), 32'(ctl_exp[7:6]));
      chk_val(32'(PWR_IND), 32'(ctl_exp[9:8]));
      chk_val(32'(SLOT_PWR_OFF), 32'(ctl_exp[CTL_PWR_OFF]));
    end
    wr(12'h0dc, 4'hf, 32'hffff_ffff);
    rd(12'h0dc, 32'h0000_0000);
    rd(SLOT_CTL_OFS, {16'h0100, ctl_exp});
    r = $random(seed);
    ovr(1'h1, r);
    rd(SLOT_CAP_OFS, cap_exp);
    ovr(1'h0, r);
    rd(SLOT_CAP_OFS, cap_exp);
    drain();
    // the link-change flag comes out of reset set, so clear it first
    wr(SLOT_CTL_OFS, 4'h8, 32'h0100_0000);
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 2; m++) begin
        wctl(16'((1 << evb[k]) | (m << CTL_HPI_EN)));
        @(posedge SYS_CLK);
        ev[k] <= 1'h1;
        @(posedge SYS_CLK);
        ev[k] <= 1'h0;
        repeat (2) @(negedge SYS_CLK);
        chk_val(32'(HP_INT), 32'(m));
        chk_val(32'(WAKE_REQ), 32'(m == 0 && evb[k] != CTL_CC_EN));
        rd(SLOT_CTL_OFS, {16'(1 << evb[k]), ctl_exp});
        wr(SLOT_CTL_OFS, 4'h4, 32'(1 << (16 + evb[k])));
        repeat (2) @(negedge SYS_CLK);
        chk_val(32'({HP_INT, WAKE_REQ}), 32'h0000_0000);
      end
    end
    wctl(16'((1 << CTL_DLL_EN) | (1 << CTL_HPI_EN)));
    @(posedge SYS_CLK);
    DL_STATE_ACTIVE <= 1'h1;
    repeat (2) @(negedge SYS_CLK);
    chk_val(32'({LINK_ACTIVE, HP_INT}), 32'h0000_0002);
    repeat (2) @(negedge SYS_CLK);
    chk_val(32'(HP_INT), 32'h0000_0001);
    rd(SLOT_CTL_OFS, {16'h0100, ctl_exp});
    // a button press in the clearing cycle must survive the clear
    fork
      wr(SLOT_CTL_OFS, 4'h4, 32'h0001_0000);
      begin
        @(posedge SYS_CLK);
        ev[0] <= 1'h1;
        @(posedge SYS_CLK);
        ev[0] <= 1'h0;
      end
    join
    rd(SLOT_CTL_OFS, {16'h0101, ctl_exp});
    drain();
    results();
  end
endmodule : tb_hot_plug_slot_cap_control
